// ==== rtl/rsc_pkg.sv ====
// Purpose: Constants for the reset scope and flag controller.
// Assumes: One 50 MHz system clock, synchronous active-low reset.
// Notes:   Register offsets are byte addresses on an AHB-Lite slave.
package rsc_pkg;

	// ---------------------------------------------------------------
	// Register map
	// ---------------------------------------------------------------
	localparam logic [7:0] RSC_OFS_STATUS = 8'h00;
	localparam logic [7:0] RSC_OFS_CTRL   = 8'h04;
	localparam logic [7:0] RSC_OFS_IRQ_ST = 8'h08;
	localparam logic [7:0] RSC_OFS_IRQ_MK = 8'h0C;
	localparam logic [7:0] RSC_OFS_LVS    = 8'h10;
	localparam logic [7:0] RSC_OFS_WDC    = 8'h14;
	localparam logic [7:0] RSC_OFS_PORTS  = 8'h18;

	// ---------------------------------------------------------------
	// Field positions and reset values
	// ---------------------------------------------------------------
	localparam int         RSC_BIT_TO        = 0;
	localparam int         RSC_BIT_PD        = 1;
	localparam int         RSC_BIT_EV_POR    = 0;
	localparam int         RSC_BIT_EV_WNORM  = 1;
	localparam int         RSC_BIT_EV_WSLP   = 2;
	localparam int         RSC_BIT_CTL_SLP   = 0;
	localparam logic [7:0] RSC_LVS_DEFAULT   = 8'h5A;
	localparam logic [7:0] RSC_WDC_DEFAULT   = 8'h57;
	localparam logic [7:0] RSC_PORT_DEFAULT  = 8'hFF;
	localparam logic [7:0] RSC_SP_TOP        = 8'h07;
	localparam logic [7:0] RSC_ZERO8         = 8'h00;
	localparam logic [2:0] RSC_ZERO3         = 3'h0;
	localparam logic [1:0] RSC_HTRANS_NONSEQ = 2'h2;

	// Power mode as seen by the reset selector.
	typedef enum logic [1:0] {
		RSC_MODE_FAST,
		RSC_MODE_SLOW,
		RSC_MODE_IDLE,
		RSC_MODE_SLEEP
	} rsc_mode_t;

endpackage

// ==== rtl/rsc_reset_ctrl.sv ====
// Purpose: Chooses reset scope per source and mode, keeps reset flags.
// Assumes: Sources are synchronous one-cycle pulses; AHB-Lite slave.
// Notes:   Power-on reset is the rst_n input itself.
`timescale 1ns/1ns

// Behaviour
// - Normal-mode watchdog expiry sets expiry flag
// - Sleep expiry clears only PC, SP; sets flag
// - Normal expiry: flag one, powerdown flag kept
// - Sleep expiry: both flags read one
// - Flags in status; power-on clears both
// - Power-on: PC zero, SP at stack top
// - Power-on disables all interrupts, global enable
// - Power-on clears watchdog, time bases; watchdog runs
// - Power-on switches all timer modules off
// - Power-on, normal expiry: ports all ones
// - Normal expiry reloads port, LVS and WDC defaults; CTRL is kept
// - Normal-mode expiry starts a full reset
module rsc_reset_ctrl (
	input  wire logic               sys_clk,
	input  wire logic               rst_n,
	input  wire logic               wdt_expire,
	input  wire rsc_pkg::rsc_mode_t power_mode,
	input  wire logic               halt_enter,
	output logic                    full_reset,
	output logic                    core_ptr_reset,
	output logic [7:0]              pc_init,
	output logic [7:0]              sp_init,
	output logic                    int_disable,
	output logic                    wdt_clear,
	output logic                    wdt_run,
	output logic                    timers_off,
	output logic [7:0]              port_data,
	output logic [7:0]              port_dir,
	output logic [7:0]              low_voltage_select_reg,
	output logic [7:0]              watchdog_control_reg,
	output logic                    watchdog_expiry_flag,
	output logic                    powerdown_flag,
	output logic                    irq,
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic [31:0]             hrdata,
	output logic                    hreadyout,
	output logic                    hresp
);
	import rsc_pkg::*;

	// Interrupt status after power-on: only the power-on event is pending.
	localparam logic [2:0] RSC_IST_POR = 3'(1) << RSC_BIT_EV_POR;

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic       por_r,  por_nxt;
	logic       full_r, full_nxt;
	logic       core_r, core_nxt;
	logic       to_r,   to_nxt;
	logic       pd_r,   pd_nxt;
	logic [7:0] lvs_r,  lvs_nxt;
	logic [7:0] wdc_r,  wdc_nxt;
	logic [7:0] pdat_r, pdat_nxt;
	logic [7:0] pdir_r, pdir_nxt;
	logic [2:0] ist_r,  ist_nxt;
	logic [2:0] imk_r,  imk_nxt;
	logic [7:0] ctl_r,  ctl_nxt;
	logic       wr_r,   wr_nxt;
	logic [7:0] wa_r,   wa_nxt;
	logic [31:0] rd_r,  rd_nxt;
	logic       sleepy;
	logic       wd_norm;
	logic       wd_sleep;
	logic       take;
	logic [2:0] ev;
	logic [31:0] wdat;
	logic       wr_status;
	logic       wr_ctrl;
	logic       wr_irq_st;
	logic       wr_irq_mk;
	logic       wr_lvs;
	logic       wr_wdc;
	logic       wr_ports;

	// Mode is sampled in the same cycle as the expiry pulse.
	assign sleepy   = (power_mode == RSC_MODE_IDLE) || (power_mode == RSC_MODE_SLEEP);
	assign wd_norm  = wdt_expire && !sleepy;
	assign wd_sleep = wdt_expire && sleepy;
	assign take     = hsel && hready && (htrans == RSC_HTRANS_NONSEQ);
	assign wdat     = hwdata;

	// Register write strobes, live in the data phase of a write transfer.
	assign wr_status = wr_r && (wa_r == RSC_OFS_STATUS);
	assign wr_ctrl   = wr_r && (wa_r == RSC_OFS_CTRL);
	assign wr_irq_st = wr_r && (wa_r == RSC_OFS_IRQ_ST);
	assign wr_irq_mk = wr_r && (wa_r == RSC_OFS_IRQ_MK);
	assign wr_lvs    = wr_r && (wa_r == RSC_OFS_LVS);
	assign wr_wdc    = wr_r && (wa_r == RSC_OFS_WDC);
	assign wr_ports  = wr_r && (wa_r == RSC_OFS_PORTS);

	// ---------------------------------------------------------------
	// Reset scope pulses
	// ---------------------------------------------------------------
	// The power-on pulse spans the first cycle after release; an expiry
	// gives its pulse in the cycle after the one in which it was seen.
	always_comb begin
		por_nxt  = 1'b0;
		full_nxt = wd_norm;
		core_nxt = wd_sleep;
	end

	// Registers the scope pulses; reset holds the power-on pulse high.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			por_r  <= 1'b1;
			full_r <= 1'b0;
			core_r <= 1'b0;
		end else begin
			por_r  <= por_nxt;
			full_r <= full_nxt;
			core_r <= core_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Reset indicator flags
	// ---------------------------------------------------------------
	// Software may rewrite both flags, but halt entry and expiries come
	// after the write, so a same-cycle set beats a clear; a normal expiry keeps the old powerdown flag.
	always_comb begin
		to_nxt = to_r;
		pd_nxt = pd_r;
		if (wr_status) begin
			to_nxt = wdat[RSC_BIT_TO];
			pd_nxt = wdat[RSC_BIT_PD];
		end
		if (halt_enter) begin
			pd_nxt = 1'b1;
		end
		if (wd_norm) begin
			to_nxt = 1'b1;
			pd_nxt = pd_r;
		end
		if (wd_sleep) begin
			to_nxt = 1'b1;
			pd_nxt = 1'b1;
		end
	end

	// Registers the flags; power-on clears both.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			to_r <= 1'b0;
			pd_r <= 1'b0;
		end else begin
			to_r <= to_nxt;
			pd_r <= pd_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Registers with power-on defaults
	// ---------------------------------------------------------------
	// Software writes land in the data phase; a normal-mode expiry then
	// reloads the power-on values of all but the control register, while a sleep expiry leaves them.
	always_comb begin
		lvs_nxt  = lvs_r;
		wdc_nxt  = wdc_r;
		pdat_nxt = pdat_r;
		pdir_nxt = pdir_r;
		ctl_nxt  = ctl_r;
		if (wr_ctrl) begin
			ctl_nxt = wdat[7:0];
		end
		if (wr_lvs) begin
			lvs_nxt = wdat[7:0];
		end
		if (wr_wdc) begin
			wdc_nxt = wdat[7:0];
		end
		if (wr_ports) begin
			pdat_nxt = wdat[7:0];
			pdir_nxt = wdat[15:8];
		end
		if (wd_norm) begin
			pdat_nxt = RSC_PORT_DEFAULT;
			pdir_nxt = RSC_PORT_DEFAULT;
			lvs_nxt  = RSC_LVS_DEFAULT;
			wdc_nxt  = RSC_WDC_DEFAULT;
		end
	end

	// Registers the defaulted state; power-on loads every default.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lvs_r  <= RSC_LVS_DEFAULT;
			wdc_r  <= RSC_WDC_DEFAULT;
			pdat_r <= RSC_PORT_DEFAULT;
			pdir_r <= RSC_PORT_DEFAULT;
			ctl_r  <= RSC_ZERO8;
		end else begin
			lvs_r  <= lvs_nxt;
			wdc_r  <= wdc_nxt;
			pdat_r <= pdat_nxt;
			pdir_r <= pdir_nxt;
			ctl_r  <= ctl_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Interrupt status and mask
	// ---------------------------------------------------------------
	// Each expiry kind raises its own sticky bit; the clear is applied
	// first so that an event in the clearing cycle survives it.
	always_comb begin
		ev = RSC_ZERO3;
		ev[RSC_BIT_EV_WNORM] = wd_norm;
		ev[RSC_BIT_EV_WSLP]  = wd_sleep;
		imk_nxt = imk_r;
		ist_nxt = ist_r;
		if (wr_irq_mk) begin
			imk_nxt = wdat[2:0];
		end
		if (wr_irq_st) begin
			ist_nxt = ist_r & ~wdat[2:0];
		end
		ist_nxt = ist_nxt | ev;
	end

	// Registers status and mask; power-on leaves the mask closed.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			imk_r <= RSC_ZERO3;
			ist_r <= RSC_IST_POR;
		end else begin
			imk_r <= imk_nxt;
			ist_r <= ist_nxt;
		end
	end

	// ---------------------------------------------------------------
	// AHB-Lite slave
	// ---------------------------------------------------------------
	// Captures the address phase and prepares read data for the data phase.
	// Read data comes from the next-state values, so a read whose address
	// phase meets the data phase of a write already sees the written value.
	always_comb begin
		wr_nxt = take && hwrite;
		wa_nxt = take ? haddr[7:0] : wa_r;
		rd_nxt = rd_r;
		if (take && !hwrite) begin
			rd_nxt = 32'h0000_0000;
			case (haddr[7:0])
				RSC_OFS_STATUS: begin
					rd_nxt[RSC_BIT_TO] = to_nxt;
					rd_nxt[RSC_BIT_PD] = pd_nxt;
				end
				RSC_OFS_CTRL:   rd_nxt[7:0]  = ctl_nxt;
				RSC_OFS_IRQ_ST: rd_nxt[2:0]  = ist_nxt;
				RSC_OFS_IRQ_MK: rd_nxt[2:0]  = imk_nxt;
				RSC_OFS_LVS:    rd_nxt[7:0]  = lvs_nxt;
				RSC_OFS_WDC:    rd_nxt[7:0]  = wdc_nxt;
				RSC_OFS_PORTS:  rd_nxt[15:0] = {pdir_nxt, pdat_nxt};
				default: ;
			endcase
		end
	end

	// Registers the bus phase state.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			wr_r <= 1'b0;
			wa_r <= RSC_ZERO8;
			rd_r <= 32'h0000_0000;
		end else begin
			wr_r <= wr_nxt;
			wa_r <= wa_nxt;
			rd_r <= rd_nxt;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	// Full reset covers power-on and normal-mode expiry alike; the core
	// pointer reset is the union of both scopes, so the core needs only it.
	assign full_reset             = por_r || full_r;
	assign core_ptr_reset         = full_reset || core_r;
	assign pc_init                = RSC_ZERO8;
	assign sp_init                = core_r ? RSC_ZERO8 : RSC_SP_TOP;
	assign int_disable            = full_reset;
	assign wdt_clear              = full_reset;
	assign wdt_run                = !full_reset;
	assign timers_off             = full_reset;
	// Data outputs come straight from their registers.
	assign port_data              = pdat_r;
	assign port_dir               = pdir_r;
	assign low_voltage_select_reg = lvs_r;
	assign watchdog_control_reg   = wdc_r;
	assign watchdog_expiry_flag   = to_r;
	assign powerdown_flag         = pd_r;
	assign irq                    = |(ist_r & imk_r);
	assign hrdata                 = rd_r;
	assign hreadyout              = 1'b1;
	assign hresp                  = 1'b0;

endmodule // rsc_reset_ctrl

// ==== tb/rsc_core_model.sv ====
// Purpose: Core model that reloads its pointers on scoped resets.
// Assumes: Pointer values come from the controller init outputs.
// Notes:   The program counter steps every cycle outside reset.
`timescale 1ns/1ns
module rsc_core_model (
	input  wire logic       sys_clk,
	input  wire logic       full_reset,
	input  wire logic       core_ptr_reset,
	input  wire logic [7:0] pc_init,
	input  wire logic [7:0] sp_init,
	output logic      [7:0] core_pc,
	output logic      [7:0] core_sp
);
	// Loads both pointers on either pulse, else the counter runs.
	always_ff @(posedge sys_clk) begin
		if (core_ptr_reset || full_reset) begin
			core_pc <= pc_init;
			core_sp <= sp_init;
		end else
			core_pc <= core_pc + 8'h01;
	end
endmodule // rsc_core_model

// ==== tb/rsc_reset_ctrl_sva.sv ====
// Purpose: Timing checks on reset scope pulses and flags.
// Assumes: Expiry pulses are never back to back.
// Notes:   Bound to the controller at the foot of the file.
`timescale 1ns/1ns
module rsc_reset_ctrl_chk (
	input wire logic               sys_clk,
	input wire logic               rst_n,
	input wire logic               wdt_expire,
	input wire rsc_pkg::rsc_mode_t power_mode,
	input wire logic               full_reset,
	input wire logic               core_ptr_reset,
	input wire logic [7:0]         pc_init,
	input wire logic [7:0]         sp_init,
	input wire logic               int_disable,
	input wire logic               wdt_clear,
	input wire logic               wdt_run,
	input wire logic               timers_off,
	input wire logic [7:0]         port_data,
	input wire logic [7:0]         port_dir,
	input wire logic [7:0]         low_voltage_select_reg,
	input wire logic [7:0]         watchdog_control_reg,
	input wire logic               watchdog_expiry_flag,
	input wire logic               powerdown_flag
);
	import rsc_pkg::*;
	logic nrm;
	logic slp;
	// Expiry split by the mode sampled in the expiry cycle.
	assign nrm = wdt_expire && !power_mode[1];
	assign slp = wdt_expire && power_mode[1];
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	AST_NRM_FULL: assert property (nrm |=> full_reset && core_ptr_reset)
		else $error("normal expiry gave no full reset");
	AST_NRM_FLAGS: assert property (nrm |=> watchdog_expiry_flag
		&& powerdown_flag == $past(powerdown_flag)) else $error("normal expiry flags wrong");
	AST_NRM_DEFS: assert property (nrm |=> port_data == 8'hFF
		&& port_dir == 8'hFF && low_voltage_select_reg == 8'h5A
		&& watchdog_control_reg == 8'h57)
		else $error("normal expiry defaults wrong");
	AST_SLP_PTR: assert property (slp |=> core_ptr_reset && !full_reset && sp_init == 8'h00)
		else $error("sleep expiry pointer reset wrong");
	AST_SLP_FLAGS: assert property (slp |=> watchdog_expiry_flag && powerdown_flag)
		else $error("sleep expiry flags wrong");
	AST_POR_FLAGS: assert property (full_reset && !$past(rst_n) |-> !watchdog_expiry_flag
		&& !powerdown_flag) else $error("power-on flags not clear");
	AST_FULL_OUTS: assert property (full_reset |-> sp_init == 8'h07 && int_disable)
		else $error("full reset outputs wrong");
	AST_FULL_CAUSE: assert property (full_reset |-> !$past(rst_n) || $past(nrm))
		else $error("full reset without cause");
	AST_FULL_SIDE: assert property (full_reset |-> wdt_clear && timers_off && !wdt_run)
		else $error("full reset side outputs wrong");
	AST_PTR_PC: assert property (core_ptr_reset |-> pc_init == 8'h00)
		else $error("pointer reset with nonzero program counter");
	COV_NRM: cover property (nrm ##1 full_reset);
	COV_SLP: cover property (slp ##1 core_ptr_reset);
	COV_POR: cover property (full_reset && !$past(rst_n));
endmodule // rsc_reset_ctrl_chk
bind rsc_reset_ctrl rsc_reset_ctrl_chk rsc_reset_ctrl_chk_inst (.sys_clk, .rst_n, .wdt_expire,
	.power_mode, .full_reset, .core_ptr_reset, .pc_init, .sp_init, .int_disable,
	.wdt_clear, .wdt_run, .timers_off, .port_data, .port_dir,
	.low_voltage_select_reg, .watchdog_control_reg, .watchdog_expiry_flag, .powerdown_flag);

// ==== tb/tb_reset_scope_and_flag_control.sv ====
// Purpose: Drives expiries per mode and checks flags and defaults.
// Assumes: Zero wait state slave; hready follows hreadyout.
// Notes:   Registers are read back over the bus after each event.
`timescale 1ns/1ns
module tb_reset_scope_and_flag_control;
	import rsc_pkg::*;
	logic        sys_clk, rst_n, wdt_expire, halt_enter, hwrite, irq;
	logic        full_reset, core_ptr_reset, hreadyout;
	rsc_mode_t   power_mode;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic [7:0]  pc_init, sp_init, core_sp, core_pc;
	int          errors, total_checks;
	rsc_reset_ctrl rsc_reset_ctrl_inst (.sys_clk, .rst_n, .wdt_expire, .power_mode,
		.halt_enter, .full_reset, .core_ptr_reset, .pc_init, .sp_init, .int_disable(),
		.wdt_clear(), .wdt_run(), .timers_off(), .port_data(), .port_dir(),
		.low_voltage_select_reg(), .watchdog_control_reg(), .watchdog_expiry_flag(),
		.powerdown_flag(), .irq, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp());
	rsc_core_model rsc_core_model_inst (.sys_clk, .full_reset, .core_ptr_reset,
		.pc_init, .sp_init, .core_pc, .core_sp);
	// Counts a comparison and reports a mismatch.
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		total_checks++;
		if (got !== ex) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// Waits for hready with a bound.
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		if (hreadyout !== 1'b1) begin
			errors++;
			complete_run();
		end
	endtask
	// One single word transfer: address phase, then data phase.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		haddr <= {24'h000000, a};
		htrans <= RSC_HTRANS_NONSEQ;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		q = hrdata;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
		bus(1'b0, a, 32'h00000000);
		chk(nm, ex, q);
	endtask
	// Holds reset for n edges, releases it and checks the power-on state.
	task automatic power_on(input int n);
		rst_n <= 1'b0;
		repeat (n) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1 chk("core_sp", 32'h7, {24'h0, core_sp});
		chk("core_pc", 32'h2, {24'h0, core_pc});
		@(posedge sys_clk);
		rd(RSC_OFS_STATUS, 32'h0, "status");
		rd(RSC_OFS_LVS, 32'h5A, "lvs");
		rd(RSC_OFS_WDC, 32'h57, "wdc");
		rd(RSC_OFS_PORTS, 32'hFFFF, "ports");
	endtask
	// Pulses an expiry and checks the scoped pulses and the core stack pointer.
	task automatic expire(input rsc_mode_t m, input logic [7:0] sp_ex);
		wdt_expire <= 1'b1;
		power_mode <= m;
		@(posedge sys_clk);
		wdt_expire <= 1'b0;
		#1 chk("full_reset", {31'h0, ~m[1]}, {31'h0, full_reset});
		chk("core_ptr_reset", 32'h1, {31'h0, core_ptr_reset});
		@(posedge sys_clk);
		#1 chk("core_sp", {24'h0, sp_ex}, {24'h0, core_sp});
		chk("core_pc", 32'h0, {24'h0, core_pc});
		@(posedge sys_clk);
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// Main sequence: power-on, bus map, interrupt, then each mode.
	initial begin
		{wdt_expire, halt_enter, hwrite, htrans, haddr, hwdata} = '0;
		power_mode = RSC_MODE_FAST;
		errors = 0;
		total_checks = 0;
		power_on(16);
		bus(1'b1, 8'h40, 32'h1);
		rd(8'h40, 32'h0, "unmapped");
		chk("irq", 32'h0, {31'h0, irq});
		bus(1'b1, RSC_OFS_IRQ_MK, 32'h1);
		rd(RSC_OFS_IRQ_ST, 32'h1, "irq_st");
		chk("irq", 32'h1, {31'h0, irq});
		bus(1'b1, RSC_OFS_IRQ_ST, 32'h1);
		rd(RSC_OFS_IRQ_ST, 32'h0, "irq_st");
		chk("irq", 32'h0, {31'h0, irq});
		halt_enter <= 1'b1;
		@(posedge sys_clk);
		halt_enter <= 1'b0;
		rd(RSC_OFS_STATUS, 32'h2, "status");
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, RSC_OFS_STATUS, (m == 1) ? 32'h2 : 32'h0);
			bus(1'b1, RSC_OFS_LVS, 32'h12);
			bus(1'b1, RSC_OFS_PORTS, 32'h0);
			expire(rsc_mode_t'(m), (m > 1) ? 8'h00 : 8'h07);
			rd(RSC_OFS_STATUS, (m == 0) ? 32'h1 : 32'h3, "status");
			rd(RSC_OFS_LVS, (m > 1) ? 32'h12 : 32'h5A, "lvs");
			rd(RSC_OFS_PORTS, (m > 1) ? 32'h0 : 32'hFFFF, "ports");
		end
		// A mid-run power-on must clear flags set by the expiries above.
		power_on(2);
		complete_run();
	end
endmodule // tb_reset_scope_and_flag_control
